// *** design/gpev_top.v ***
// gpio pin event detection, power-well emulation and pull select
//
// What this block does
// - one edge-enable bit per pin; 0 disables, 1 enables edge detection.
// - detect field with edge-enable chooses the condition raising a pin event.
// - codes 0000 low,0001 high,0100 off,1101 rise,1110 fall,1111 either.
// - event input path stays live when the pin runs an alternate function.
// - analog alternate function pins need not detect pin activity.
// - pin tristates whenever its selected power well is off.
// - every pin gets power gating unless marked as an exception.
// - gate code 00 tristates output while main rail power good is low.
// - gate code 10 tristates, disables in and out, lowest power; 11 reserved.
// - battery-rail pins stay powered; no emulation whatever the field.
// - two-bit pull select per pin drives pull-up or pull-down enable.
// - pull code 00 enables no pull resistor.
// - pull code 01 enables the internal pull-up.
`include "gpev_defs.vh"
module gpev_top #(
  // pins powered from the battery rail, never gated
  parameter [7:0] BATTERY_PINS = 8'h00,
  // pins with an analog alternate function
  parameter [7:0] ANALOG_PINS = 8'h00,
  // pins exempt from power gating
  parameter [7:0] NOGATE_PINS = 8'h00
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // power status and alternate function select
  input wire main_rail_power_good,
  input wire [7:0] analog_sel,
  // pads
  input wire [7:0] pad_in,
  input wire [7:0] pad_out,
  output wire [7:0] pad_oe_n,
  output wire [7:0] pad_in_en,
  output wire [7:0] pad_low_power,
  output wire [7:0] pad_pull_up,
  output wire [7:0] pad_pull_down,
  output wire [7:0] pad_dout,
  // events
  output wire [7:0] pin_event,
  output wire irq
);
  reg [31:0] evcfg_ff;
  reg [31:0] pwcfg_ff;
  reg [7:0] stat_ff;
  reg [7:0] mask_ff;
  reg [7:0] paden_ff;
  reg [31:0] nxt_prdata;
  wire [7:0] pin_sync;
  wire [7:0] ev_raw;
  wire [7:0] gated;
  wire [7:0] unpwr;
  wire wr_en;
  wire rd_en;
  wire addr_ok;

  // apb handshake: zero wait state, error on unmapped address
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite & ~penable;
  assign pready = 1'b1;
  assign addr_ok = (paddr == `GPEV_OFF_EVCFG) | (paddr == `GPEV_OFF_PWCFG) |
    (paddr == `GPEV_OFF_STAT) | (paddr == `GPEV_OFF_MASK) |
    (paddr == `GPEV_OFF_PIN) | (paddr == `GPEV_OFF_PADEN);
  assign pslverr = psel & penable & ~addr_ok;

  // configuration registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evcfg_ff <= `GPEV_EVCFG_RST;
      pwcfg_ff <= `GPEV_PWCFG_RST;
      mask_ff <= `GPEV_ZERO8;
      paden_ff <= `GPEV_ZERO8;
    end
    else if (wr_en)
    begin
      if (paddr == `GPEV_OFF_EVCFG)
        evcfg_ff <= pwdata;
      if (paddr == `GPEV_OFF_PWCFG)
        pwcfg_ff <= pwdata;
      if (paddr == `GPEV_OFF_MASK)
        mask_ff <= pwdata[7:0];
      if (paddr == `GPEV_OFF_PADEN)
        paden_ff <= pwdata[7:0];
    end
  end

  // per-pin datapath
  genvar i;
  generate
    for (i = 0; i < `GPEV_NPINS; i = i + 1)
    begin : g_pin
      wire [1:0] pg_sel;
      wire [1:0] pull_sel;
      wire gate_ok;
      wire off_main;
      // power_gate_select and pull_resistor_select fields
      assign pg_sel = pwcfg_ff[i*`GPEV_PWW +: 2];
      assign pull_sel = pwcfg_ff[i*`GPEV_PWW + 2 +: 2];
      // battery pins and exempt pins skip emulation
      assign gate_ok = ~BATTERY_PINS[i] & ~NOGATE_PINS[i];
      assign unpwr[i] = gate_ok & (pg_sel == `GPEV_PG_UNPWR);
      assign off_main = gate_ok & (pg_sel == `GPEV_PG_MAIN) &
        ~main_rail_power_good;
      assign gated[i] = unpwr[i] | off_main;
      // output enable low means driving
      assign pad_oe_n[i] = ~paden_ff[i] | gated[i];
      assign pad_in_en[i] = ~unpwr[i];
      assign pad_low_power[i] = unpwr[i];
      // pulls off in lowest-power state
      assign pad_pull_up[i] = (pull_sel == `GPEV_PULL_UP) & ~unpwr[i];
      assign pad_pull_down[i] = (pull_sel == `GPEV_PULL_DOWN) &
        ~unpwr[i];
      // input path independent of mux select, so alt functions still
      // raise events; analog inputs are masked to avoid chatter
      gpev_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d_in(pad_in[i]),
        .q_out(pin_sync[i])
      );
      gpev_detect u_det (
        .pclk(pclk),
        .presetn(presetn),
        .ev_code(evcfg_ff[i*`GPEV_EVW +: `GPEV_EVW]),
        .in_en(~unpwr[i] & ~(ANALOG_PINS[i] & analog_sel[i])),
        .pin_sync(pin_sync[i]),
        .event_out(ev_raw[i])
      );
    end
  endgenerate

  // output data registered so the pad sees clean levels
  reg [7:0] dout_ff;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dout_ff <= `GPEV_ZERO8;
    else
      dout_ff <= pad_out & ~unpwr;
  end
  assign pad_dout = dout_ff;
  assign pin_event = ev_raw;

  // sticky status, write one to clear; a new event wins over the clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_ff <= `GPEV_ZERO8;
    else if (wr_en && paddr == `GPEV_OFF_STAT)
      stat_ff <= (stat_ff & ~pwdata[7:0]) | ev_raw;
    else
      stat_ff <= stat_ff | ev_raw;
  end
  assign irq = |(stat_ff & mask_ff);

  // read mux, captured in setup phase; reserved bits read zero
  always @*
  begin
    nxt_prdata = `GPEV_ZERO32;
    case (paddr)
      `GPEV_OFF_EVCFG: nxt_prdata = evcfg_ff;
      `GPEV_OFF_PWCFG: nxt_prdata = pwcfg_ff;
      `GPEV_OFF_STAT: nxt_prdata[7:0] = stat_ff;
      `GPEV_OFF_MASK: nxt_prdata[7:0] = mask_ff;
      `GPEV_OFF_PIN: nxt_prdata[7:0] = pin_sync;
      `GPEV_OFF_PADEN: nxt_prdata[7:0] = paden_ff;
      default: nxt_prdata = `GPEV_ZERO32;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= `GPEV_ZERO32;
    else if (rd_en)
      prdata <= nxt_prdata;
  end
endmodule // gpev_top

// *** include/gpev_defs.vh ***
// constants for the gpio pin event and power gating block
`ifndef GPEV_DEFS_VH
`define GPEV_DEFS_VH
`define GPEV_NPINS 8
`define GPEV_ADDR_W 12
// register byte offsets
`define GPEV_OFF_EVCFG 12'h000
`define GPEV_OFF_PWCFG 12'h004
`define GPEV_OFF_STAT 12'h008
`define GPEV_OFF_MASK 12'h00c
`define GPEV_OFF_PIN 12'h010
`define GPEV_OFF_PADEN 12'h014
// event config: 4 bits per pin, bit 3 edge enable, bits 2:0 detect
`define GPEV_EVW 4
`define GPEV_EV_LOW 4'h0
`define GPEV_EV_HIGH 4'h1
`define GPEV_EV_OFF 4'h4
`define GPEV_EV_RISE 4'hd
`define GPEV_EV_FALL 4'he
`define GPEV_EV_BOTH 4'hf
`define GPEV_EVCFG_RST 32'h0000_0000
// power config: 4 bits per pin, bits 1:0 gate select, bits 3:2 pull
`define GPEV_PWW 4
`define GPEV_PG_MAIN 2'h0
`define GPEV_PG_UNPWR 2'h2
`define GPEV_PULL_NONE 2'h0
`define GPEV_PULL_UP 2'h1
`define GPEV_PULL_DOWN 2'h2
`define GPEV_PWCFG_RST 32'h0000_0000
`define GPEV_ZERO8 8'h00
`define GPEV_ZERO32 32'h0000_0000
`endif

// *** design/gpev_sync.v ***
// two-flop synchroniser for one pad input
module gpev_sync (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // data
  input wire d_in,
  output wire q_out
);
  reg meta_ff;
  reg sync_ff;

  // first flop feeds only the second one
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;
endmodule // gpev_sync

// *** design/gpev_detect.v ***
// per-pin event detector: level or edge, selected by a 4-bit code
`include "gpev_defs.vh"
module gpev_detect (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // configuration and input
  input wire [3:0] ev_code,
  input wire in_en,
  input wire pin_sync,
  // event
  output wire event_out
);
  reg prev_ff;
  reg hit;

  // previous synchronised sample for edge compare
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_ff <= 1'b0;
    else
      prev_ff <= pin_sync;
  end

  // decode; reserved codes raise nothing
  always @*
  begin
    case (ev_code)
      `GPEV_EV_LOW: hit = ~pin_sync;
      `GPEV_EV_HIGH: hit = pin_sync;
      `GPEV_EV_RISE: hit = pin_sync & ~prev_ff;
      `GPEV_EV_FALL: hit = ~pin_sync & prev_ff;
      `GPEV_EV_BOTH: hit = pin_sync ^ prev_ff;
      default: hit = 1'b0;
    endcase
  end

  // unpowered input path gives no events
  assign event_out = hit & in_en;
endmodule // gpev_detect

// *** dv/gpev_properties.sv ***
// checker for pin 0 gating, pull and event behaviour
module gpev_chk (
  // clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // pad side
  input wire logic main_rail_power_good,
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pad_in_en,
  input wire logic [7:0] pad_low_power,
  input wire logic [7:0] pad_pull_up,
  input wire logic [7:0] pad_pull_down,
  input wire logic [7:0] pin_event
);
  logic [31:0] ev_ff, pw_ff;
  logic [7:0] en_ff;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow config words so outputs can be tied to what software wrote
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      {ev_ff, pw_ff, en_ff} <= '0;
    else if (psel && penable && pwrite)
      case (paddr)
        12'h000: ev_ff <= pwdata;
        12'h004: pw_ff <= pwdata;
        12'h014: en_ff <= pwdata[7:0];
        default: ;
      endcase
  a_unpwr_parked: assert property (pw_ff[1:0] == 2'h2
    |-> pad_oe_n[0] && !pad_in_en[0] && pad_low_power[0])
    else $error("unpowered pin not parked");
  a_rail_gate: assert property (pw_ff[1:0] == 2'h0
    && !main_rail_power_good |-> pad_oe_n[0])
    else $error("pin driven with rail down");
  a_drive_on: assert property (pw_ff[1:0] == 2'h0
    && main_rail_power_good |-> pad_oe_n[0] == !en_ff[0])
    else $error("drive enable wrong");
  a_pull_up: assert property (pw_ff[3:0] == 4'h4
    |-> pad_pull_up[0] && !pad_pull_down[0])
    else $error("pull-up missing");
  a_pull_none: assert property (pw_ff[3:2] == 2'h0
    |-> !(pad_pull_up[0] || pad_pull_down[0]))
    else $error("pull on with code none");
  a_rise_pulse: assert property (ev_ff[3:0] == 4'hd && $rose(pad_in[0])
    |-> ##2 pin_event[0] ##1 !pin_event[0])
    else $error("rise pulse wrong");
  a_off_quiet: assert property (ev_ff[3:0] == 4'h4 |-> !pin_event[0])
    else $error("event while disabled");
  a_level_high: assert property (ev_ff[3:0] == 4'h1 && pw_ff[1:0] != 2'h2
    && $past(presetn) && $past(presetn, 2) |-> pin_event[0] == $past(pad_in[0], 2))
    else $error("high level event wrong");
endmodule // gpev_chk

bind gpev_top gpev_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .main_rail_power_good, .pad_in, .pad_oe_n, .pad_in_en,
  .pad_low_power, .pad_pull_up, .pad_pull_down, .pin_event);

// *** dv/gpev_pad.sv ***
// pad model: pin level from block driver, pulls and an outside source
module gpev_pad (
  // clock
  input wire logic pclk,
  // from the block
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pad_dout,
  input wire logic [7:0] pad_pull_up,
  input wire logic [7:0] pad_pull_down,
  // outside source
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // level seen by the block
  output logic [7:0] pad_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] flt_ff = 8'h00;
  // a floating pin wanders so a stale level is never read as valid
  always @(posedge pclk)
    flt_ff <= ~flt_ff;
  // block drive first, then outside source, then pulls
  always_comb
    for (int i = 0; i < 8; i++)
      pad_lvl[i] = !pad_oe_n[i] ? pad_dout[i] : ext_en[i] ? ext_val[i] :
        pad_pull_up[i] ? 1'b1 : pad_pull_down[i] ? 1'b0 : flt_ff[i];
endmodule // gpev_pad

// *** dv/gpev_top_tb.sv ***
// self-checking bench for the pin event and power gating block
`include "gpev_defs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module gpev_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic main_rail_power_good = 1, pready, pslverr, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [7:0] analog_sel = 0, pad_out = 0, ext_en = 8'hff, ext_val = 0;
  logic [7:0] pad_lvl, pad_oe_n, pad_in_en, pad_low_power, pad_dout;
  logic [7:0] pad_pull_up, pad_pull_down, pin_event;
  logic [63:0] exp_q[$], ex;
  logic [6:0] tbl [12] = '{{4'hd, 3'b011}, {4'hd, 3'b100}, {4'he, 3'b101},
    {4'he, 3'b010}, {4'hf, 3'b101}, {4'hf, 3'b011}, {4'h1, 3'b111},
    {4'h1, 3'b000}, {4'h0, 3'b001}, {4'h0, 3'b110}, {4'h4, 3'b010},
    {4'h5, 3'b010}};
  int failures = 0, check_count = 0, cyc = 0;
  gpev_top #(.BATTERY_PINS(8'h04)) i_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .main_rail_power_good, .analog_sel,
    .pad_in(pad_lvl), .pad_out, .pad_oe_n, .pad_in_en, .pad_low_power,
    .pad_pull_up, .pad_pull_down, .pad_dout, .pin_event, .irq);
  gpev_pad i_pad (.pclk, .pad_oe_n, .pad_dout, .pad_pull_up, .pad_pull_down,
    .ext_en, .ext_val, .pad_lvl);
  initial forever #2.5 pclk = ~pclk;
  task tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer; a read notes its expected word and mask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] m);
    if (!w)
      exp_q.push_back({m, d});
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  // read monitor takes the oldest note when read data is sampled
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
    begin
      ex = exp_q.pop_front();
      `CHK(prdata & ex[63:32], ex[31:0])
      `CHK(pslverr, paddr > `GPEV_OFF_PADEN)
    end
  // cycle ceiling: the tests need well under a thousand cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  initial
  begin
    void'($urandom(53375));
    // random traffic on other pins and alternate selects; forked after
    // the seed so that it draws from the seeded generator
    fork
      forever @(posedge pclk)
        {analog_sel, ext_val[7:1]} <= 15'($urandom);
    join_none
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `GPEV_OFF_EVCFG, `GPEV_EVCFG_RST, 32'hffffffff);
    apb(0, 12'h018, 32'h0, 32'hffffffff);
    for (int i = 0; i < 12; i++)
    begin
      ext_val[0] <= tbl[i][2];
      repeat (4) @(posedge pclk);
      apb(1, `GPEV_OFF_EVCFG, {28'h4444444, tbl[i][6:3]}, 0);
      apb(1, `GPEV_OFF_STAT, 32'hff, 0);
      ext_val[0] <= tbl[i][1];
      repeat (4) @(posedge pclk);
      apb(0, `GPEV_OFF_STAT, {31'h0, tbl[i][0]}, 32'h1);
    end
    apb(1, `GPEV_OFF_EVCFG, 32'h4444444d, 0);
    ext_val[0] <= 1'b0;
    apb(1, `GPEV_OFF_STAT, 32'hff, 0);
    apb(1, `GPEV_OFF_MASK, 32'h1, 0);
    ext_val[0] <= 1'b1;
    repeat (4) @(posedge pclk);
    #1 `CHK(irq, 1'b1)
    apb(1, `GPEV_OFF_STAT, 32'h1, 0);
    #1 `CHK(irq, 1'b0)
    // later stimulus lands on the rising edge again
    @(posedge pclk);
    ext_en <= 8'hfe;
    pad_out <= 8'h01;
    // pin 2 is a battery pin: it must keep driving with the rail down
    apb(1, `GPEV_OFF_PADEN, 32'h5, 0);
    // a new pad level needs two edges before the synced read sees it
    repeat (2) @(posedge pclk);
    #1 `CHK(pad_dout[0], 1'b1)
    apb(0, `GPEV_OFF_PIN, 32'h1, 32'h1);
    main_rail_power_good <= 1'b0;
    apb(1, `GPEV_OFF_PWCFG, 32'h8, 0);
    repeat (2) @(posedge pclk);
    #1 `CHK(pad_oe_n[2], 1'b0)
    apb(0, `GPEV_OFF_PIN, 32'h0, 32'h1);
    apb(1, `GPEV_OFF_PWCFG, 32'h4, 0);
    repeat (2) @(posedge pclk);
    apb(0, `GPEV_OFF_PIN, 32'h1, 32'h1);
    main_rail_power_good <= 1'b1;
    apb(1, `GPEV_OFF_PWCFG, 32'h2, 0);
    #1 `CHK(pad_oe_n[0], 1'b1)
    // let the checker and the output flop see the unpowered state
    repeat (2) @(posedge pclk);
    #1 `CHK(pad_dout[0], 1'b0)
    tally_and_finish();
  end
endmodule // gpev_top_tb
